// ===== rtl/lpt_target.sv
// lpt_target.sv: peripheral side of the low pin count bus
// assumes clk is the bus clock and nrst the host bus reset
`timescale 1ns/10ps
module lpt_target
	import lpt_pkg::*;
(
	// clock and host bus reset
	input wire logic clk, // keeps running, no stop handshake
	input wire logic nrst,
	// bus pins
	input wire logic lframe_n,
	input wire logic [3:0] lad_in,
	output logic [3:0] lad_out,
	output logic lad_oe,
	output logic ldrq_n,
	input wire logic lpcpd_n,
	// wake request, open drain
	input wire logic wake_request,
	output logic wake_event_request_n,
	output logic wake_oe,
	// function windows
	input wire logic [`LPT_NUM_WIN*16-1:0] win_base,
	input wire logic [`LPT_NUM_WIN*16-1:0] win_mask,
	input wire logic [`LPT_NUM_WIN-1:0] win_en,
	// register access toward the functions
	output logic [15:0] io_addr,
	output lpt_byte_type io_wdata,
	output logic io_wr,
	output logic io_rd,
	output logic [`LPT_NUM_WIN-1:0] io_sel,
	input wire lpt_byte_type io_rdata,
	// dma channel ownership and request
	input wire logic [2:0] dma_chan,
	input wire logic dma_en,
	input wire logic dma_req,
	input wire logic dma_req_act,
	output logic dma_req_busy,
	// dma data toward the host
	input wire lpt_byte_type dma_tx_data,
	output logic dma_tx_take,
	// dma data from the host, buffered
	input wire logic dma_rx_pop,
	output lpt_byte_type dma_rx_data,
	output logic dma_rx_avail
);
	// pin synchronisers
	logic lframe_m_q, lframe_s_q, lpcpd_m_q, lpcpd_s_q, wake_m_q, wake_s_q;
	logic [3:0] lad_m_q, lad_s_q;
	// decoder state
	lpt_state_type state_q, state_d;
	logic [1:0] nib_q, nib_d, bytes_q, bytes_d;
	logic [2:0] wait_q, wait_d;
	logic io_q, io_d, wr_q, wr_d, hit_q, hit_d;
	logic [15:0] addr_q, addr_d;
	lpt_byte_type data_q, data_d;
	logic [3:0] lad_d;
	logic lad_oe_d, io_wr_d, io_rd_d, take_d, push_d;
	logic [`LPT_NUM_WIN-1:0] sel_q, win_hit_v;
	// dma request serializer and buffer pointers
	logic [`LPT_REQ_BITS-1:0] req_sh_q;
	logic [2:0] req_cnt_q;
	logic req_busy_q, ldrq_q, wake_q;
	logic [`LPT_BUF_AW-1:0] wp_q, rp_q;
	logic [3:0] cnt_q;
	logic avail_q;

	// address matches a window when the unmasked bits agree
	function automatic logic in_window(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] m);
		in_window = ((a ^ b) & ~m) == 16'h0000;
	endfunction

	wire [15:0] addr_full = {addr_q[11:0], lad_s_q};
	wire frame_on = !lframe_s_q;
	wire start_seen = frame_on && (lad_s_q == `LPT_START);
	wire buf_full = (cnt_q == `LPT_BUF_DEPTH);
	wire dev_sends = io_q ? !wr_q : wr_q;
	wire [2:0] wait_load = io_q ? (wr_q ? `LPT_WAIT_IO_WR : `LPT_WAIT_IO_RD)
		: (wr_q ? `LPT_WAIT_DMA_WR : `LPT_WAIT_DMA_RD);
	wire [3:0] wait_code = io_q ? `LPT_SYNC_LONG : `LPT_SYNC_SHORT;
	wire rx_err = !io_q && !wr_q && buf_full;
	wire pop_ok = dma_rx_pop && avail_q;

	// window comparators, one per function
	genvar gi;
	generate
		for (gi = 0; gi < `LPT_NUM_WIN; gi++) begin : g_win
			assign win_hit_v[gi] = win_en[gi] && in_window(addr_full,
				win_base[gi*16 +: 16], win_mask[gi*16 +: 16]);
		end
	endgenerate

	// two flops on every pin input
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{lframe_m_q, lframe_s_q, lpcpd_m_q, lpcpd_s_q} <= 4'hF;
			{wake_m_q, wake_s_q} <= 2'h0;
			{lad_m_q, lad_s_q} <= 8'hFF;
		end else begin
			{lframe_m_q, lframe_s_q} <= {lframe_n, lframe_m_q};
			{lpcpd_m_q, lpcpd_s_q} <= {lpcpd_n, lpcpd_m_q};
			{wake_m_q, wake_s_q} <= {wake_request, wake_m_q};
			{lad_m_q, lad_s_q} <= {lad_in, lad_m_q};
		end
	end

	// cycle decoder; idle only compares the frame line and the start code
	always_comb begin
		state_d = state_q;
		nib_d = nib_q;
		bytes_d = bytes_q;
		wait_d = wait_q;
		io_d = io_q;
		wr_d = wr_q;
		hit_d = hit_q;
		addr_d = addr_q;
		data_d = data_q;
		lad_d = `LPT_LINES_HIGH;
		lad_oe_d = 1'b0;
		io_wr_d = 1'b0;
		io_rd_d = 1'b0;
		take_d = 1'b0;
		push_d = 1'b0;
		unique case (state_q)
			ST_IDLE: ;
			ST_CT: begin
				nib_d = 2'h0;
				wr_d = lad_s_q[1];
				if (lad_s_q[3:2] == `LPT_CT_IO) begin
					io_d = 1'b1;
					state_d = ST_ADDR;
				end else if (lad_s_q[3:2] == `LPT_CT_DMA) begin
					io_d = 1'b0;
					state_d = ST_CHAN;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_ADDR: begin
				addr_d = addr_full;
				nib_d = nib_q + 2'h1;
				if (nib_q == `LPT_ADDR_LAST) begin
					hit_d = |win_hit_v;
					nib_d = 2'h0;
					bytes_d = 2'h0;
					state_d = wr_q ? ST_HDATA : ST_TAR_IN;
				end
			end
			ST_CHAN: begin
				hit_d = dma_en && (lad_s_q[2:0] == dma_chan);
				state_d = ST_SIZE;
			end
			ST_SIZE: begin
				nib_d = 2'h0;
				bytes_d = lad_s_q[1:0];
				if (lad_s_q[1:0] == `LPT_SIZE_RSVD) begin
					state_d = ST_IDLE;
				end else begin
					state_d = wr_q ? ST_TAR_IN : ST_HDATA;
				end
			end
			ST_HDATA: begin
				data_d = {lad_s_q, data_q[7:4]};
				nib_d = nib_q + 2'h1;
				if (nib_q == `LPT_NIB_LAST) begin
					nib_d = 2'h0;
					state_d = ST_TAR_IN;
				end
			end
			ST_TAR_IN: begin
				nib_d = nib_q + 2'h1;
				if (nib_q == `LPT_NIB_LAST) begin
					nib_d = 2'h0;
					wait_d = wait_load;
					io_rd_d = io_q && !wr_q && hit_q;
					state_d = hit_q ? ST_SYNC : ST_IDLE;
				end
			end
			ST_SYNC: begin
				lad_oe_d = 1'b1;
				if (wait_q != 3'h0) begin
					lad_d = wait_code;
					wait_d = wait_q - 3'h1;
				end else begin
					lad_d = rx_err ? `LPT_SYNC_ERROR : `LPT_SYNC_READY;
					io_wr_d = io_q && wr_q;
					push_d = !io_q && !wr_q && !buf_full;
					take_d = !io_q && wr_q;
					if (dev_sends) begin
						data_d = io_q ? io_rdata : dma_tx_data;
					end
					if (rx_err) begin
						bytes_d = 2'h0; // error ends a multi-byte cycle
					end
					state_d = dev_sends ? ST_DDATA : ST_TAR_OUT;
				end
			end
			ST_DDATA: begin
				lad_oe_d = 1'b1;
				lad_d = (nib_q == 2'h0) ? data_q[3:0] : data_q[7:4];
				nib_d = nib_q + 2'h1;
				if (nib_q == `LPT_NIB_LAST) begin
					nib_d = 2'h0;
					if (!io_q && bytes_q != 2'h0) begin
						bytes_d = bytes_q - 2'h1;
						wait_d = wait_load;
						state_d = ST_SYNC;
					end else begin
						state_d = ST_TAR_OUT;
					end
				end
			end
			ST_TAR_OUT: begin
				lad_oe_d = (nib_q == 2'h0);
				nib_d = nib_q + 2'h1;
				if (nib_q == `LPT_NIB_LAST) begin
					nib_d = 2'h0;
					if (!io_q && !wr_q && bytes_q != 2'h0) begin
						// pin flops still hold our own turnaround; skip it
						if (wait_q != `LPT_GAP_DMA_RD) begin
							wait_d = wait_q + 3'h1;
							nib_d = nib_q;
						end else begin
							wait_d = 3'h0;
							bytes_d = bytes_q - 2'h1;
							state_d = ST_HDATA;
						end
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
		endcase
		// frame overrides everything but the power-down notice; release the lines next clock
		if (frame_on) begin
			state_d = start_seen ? ST_CT : ST_IDLE;
			lad_oe_d = 1'b0;
			io_wr_d = 1'b0;
			io_rd_d = 1'b0;
			take_d = 1'b0;
			push_d = 1'b0;
		end
		// power-down notice parks the decoder quietly
		if (!lpcpd_s_q) begin
			state_d = ST_IDLE;
			lad_oe_d = 1'b0;
			io_wr_d = 1'b0;
			io_rd_d = 1'b0;
			take_d = 1'b0;
			push_d = 1'b0;
		end
	end

	// decoder registers; reset floats the lines
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			{nib_q, bytes_q, wait_q} <= 7'h00;
			{io_q, wr_q, hit_q} <= 3'h0;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
			lad_out <= `LPT_LINES_HIGH;
			lad_oe <= 1'b0;
			{io_wr, io_rd, dma_tx_take} <= 3'h0;
			sel_q <= '0;
		end else begin
			state_q <= state_d;
			{nib_q, bytes_q, wait_q} <= {nib_d, bytes_d, wait_d};
			{io_q, wr_q, hit_q} <= {io_d, wr_d, hit_d};
			addr_q <= addr_d;
			data_q <= data_d;
			lad_out <= lad_d;
			lad_oe <= lad_oe_d;
			{io_wr, io_rd, dma_tx_take} <= {io_wr_d, io_rd_d, take_d};
			if (state_q == ST_ADDR && nib_q == `LPT_ADDR_LAST) begin
				sel_q <= win_hit_v;
			end
		end
	end

	// encoded dma request: start bit, channel msb first, active, then idle high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_sh_q <= '1;
			req_cnt_q <= 3'h0;
			req_busy_q <= 1'b0;
			ldrq_q <= 1'b1;
		end else if (!lpcpd_s_q) begin
			req_busy_q <= 1'b0;
			ldrq_q <= 1'b1;
		end else if (!req_busy_q) begin
			ldrq_q <= 1'b1;
			if (dma_req) begin
				req_sh_q <= {1'b0, dma_chan, dma_req_act};
				req_cnt_q <= 3'h0;
				req_busy_q <= 1'b1;
			end
		end else begin
			ldrq_q <= req_sh_q[`LPT_REQ_BITS-1];
			req_sh_q <= {req_sh_q[`LPT_REQ_BITS-2:0], 1'b1};
			req_cnt_q <= req_cnt_q + 3'h1;
			if (req_cnt_q == `LPT_REQ_LAST) begin
				req_busy_q <= 1'b0;
			end
		end
	end

	// host-to-device dma bytes, read back by the function side
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{wp_q, rp_q} <= '0;
			cnt_q <= 4'h0;
			avail_q <= 1'b0;
		end else begin
			wp_q <= wp_q + {2'h0, push_d};
			rp_q <= rp_q + {2'h0, pop_ok};
			cnt_q <= cnt_q + {3'h0, push_d} - {3'h0, pop_ok};
			avail_q <= (cnt_q + {3'h0, push_d} - {3'h0, pop_ok}) != 4'h0;
		end
	end

	lpt_buf u_buf (
		.clk(clk),
		.nrst(nrst),
		.wr_en(push_d),
		.wr_addr(wp_q),
		.wr_data(data_q),
		.rd_addr(rp_q),
		.rd_data(dma_rx_data)
	);

	// open-drain wake line, pulled low while asked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_s_q;
		end
	end

	assign wake_event_request_n = 1'b0;
	assign wake_oe = wake_q;
	assign ldrq_n = ldrq_q;
	assign dma_req_busy = req_busy_q;
	assign dma_rx_avail = avail_q;
	assign io_addr = addr_q;
	assign io_wdata = data_q;
	assign io_sel = sel_q;
endmodule

// ===== rtl/lpt_map.svh
// lpt_map.svh: named constants of the low pin count target port
// assumes inclusion by bare name from the package; the design files rely on that inclusion
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// field codes seen on the multiplexed nibble lines
`define LPT_START 4'h0
`define LPT_CT_IO 2'h0
`define LPT_CT_DMA 2'h2
`define LPT_SIZE_1 2'h0
`define LPT_SIZE_2 2'h1
`define LPT_SIZE_4 2'h3
`define LPT_SIZE_RSVD 2'h2
// handshake codes driven by the target
`define LPT_SYNC_READY 4'h0
`define LPT_SYNC_SHORT 4'h5
`define LPT_SYNC_LONG 4'h6
`define LPT_SYNC_ERROR 4'hA
`define LPT_LINES_HIGH 4'hF
// wait states per cycle kind
`define LPT_WAIT_IO_RD 3'h3
`define LPT_WAIT_IO_WR 3'h2
`define LPT_WAIT_DMA_RD 3'h3
`define LPT_WAIT_DMA_WR 3'h4
// idle clocks after a dma read turnaround until the next host byte reaches the decoder
`define LPT_GAP_DMA_RD 3'h3
// nibble counts and geometry
`define LPT_ADDR_LAST 2'h3
`define LPT_NIB_LAST 2'h1
`define LPT_NUM_WIN 6
`define LPT_BUF_AW 3
`define LPT_BUF_DEPTH 4'h8
`define LPT_REQ_BITS 5
`define LPT_REQ_LAST 3'h4
`endif

// ===== rtl/lpt_pkg.sv
// lpt_pkg.sv: types shared by the low pin count target port files
// assumes lpt_map.svh is reachable on the include path
`include "lpt_map.svh"
package lpt_pkg;
	// cycle decoder states
	typedef enum logic [3:0] {
		ST_IDLE, ST_CT, ST_ADDR, ST_CHAN, ST_SIZE, ST_HDATA,
		ST_TAR_IN, ST_SYNC, ST_DDATA, ST_TAR_OUT
	} lpt_state_type;
	typedef logic [7:0] lpt_byte_type;
endpackage

// ===== rtl/lpt_buf.sv
// lpt_buf.sv: small byte store for data the host sends by dma
// assumes one clock; read data comes out of a register
`timescale 1ns/10ps
module lpt_buf
	import lpt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// write side
	input wire logic wr_en,
	input wire logic [`LPT_BUF_AW-1:0] wr_addr,
	input wire lpt_byte_type wr_data,
	// read side
	input wire logic [`LPT_BUF_AW-1:0] rd_addr,
	output lpt_byte_type rd_data
);
	lpt_byte_type mem [0:(1<<`LPT_BUF_AW)-1];
	lpt_byte_type rd_q;

	// storage write, no reset on the array
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= mem[rd_addr];
		end
	end

	assign rd_data = rd_q;
endmodule

// ===== test/lpt_target_assertions.sv
// lpt_target_assertions.sv: port checks on lpt_target
// assumes bind into every lpt_target, one clock
`timescale 1ns/10ps
module lpt_chk
	import lpt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bus pins
	input wire logic lframe_n,
	input wire logic lpcpd_n,
	input wire logic [3:0] lad_out,
	input wire logic lad_oe,
	input wire logic ldrq_n,
	// wake and access
	input wire logic wake_request,
	input wire logic wake_event_request_n,
	input wire logic wake_oe,
	input wire logic io_wr,
	// dma request
	input wire logic [2:0] dma_chan,
	input wire logic dma_req,
	input wire logic dma_req_act,
	input wire logic dma_req_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// quiet pins right after reset
	property p_rst;
		$rose(nrst) |-> !lad_oe && ldrq_n && !wake_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("pins busy after reset");
	// frame seen, lines let go
	property p_rel;
		!lframe_n |-> ##3 !lad_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("lines held after frame");
	// last driven nibble is all ones
	property p_tar;
		$fell(lad_oe) |-> $past(lad_out) == 4'hF;
	endproperty
	a_tar: assert property (p_tar) else $error("turnaround not high");
	// i/o waits use the long code
	property p_io;
		$rose(lad_oe) && lad_out == 4'h6 |-> (lad_oe && lad_out == 4'h6) [*2]
			##1 (lad_oe && lad_out inside {4'h0, 4'h6});
	endproperty
	a_io: assert property (p_io) else $error("i/o wait run wrong");
	// dma waits use the short code
	property p_dma;
		$rose(lad_oe) && lad_out == 4'h5 |-> (lad_oe && lad_out == 4'h5) [*3]
			##1 (lad_oe && lad_out inside {4'h0, 4'h5, 4'hA});
	endproperty
	a_dma: assert property (p_dma) else $error("dma wait run wrong");
	// write strobe after exactly two waits
	property p_wr;
		io_wr |-> lad_oe && lad_out == 4'h0 && $past(lad_out) == 4'h6
			&& $past(lad_out, 2) == 4'h6 && $past(lad_oe, 2) && !$past(lad_oe, 3);
	endproperty
	a_wr: assert property (p_wr) else $error("write strobe misplaced");
	// encoded request frame
	property p_rq;
		dma_req && !dma_req_busy |-> ##2 !ldrq_n ##1 ldrq_n == dma_chan[2]
			##1 ldrq_n == dma_chan[1] ##1 ldrq_n == dma_chan[0]
			##1 ldrq_n == dma_req_act ##1 ldrq_n;
	endproperty
	a_rq: assert property (p_rq) else $error("request frame wrong");
	// open-drain wake pull
	property p_wk;
		wake_oe == $past(wake_request, 3) && !wake_event_request_n;
	endproperty
	a_wk: assert property (p_wk) else $error("wake pull wrong");
	// power-down notice quiets the port
	property p_pd;
		!lpcpd_n [*4] |-> !lad_oe && ldrq_n;
	endproperty
	a_pd: assert property (p_pd) else $error("active in power-down");
endmodule
bind lpt_target lpt_chk lpt_chk_i (.clk, .nrst, .lframe_n, .lpcpd_n, .lad_out, .lad_oe,
	.ldrq_n, .wake_request, .wake_event_request_n, .wake_oe, .io_wr, .dma_chan,
	.dma_req, .dma_req_act, .dma_req_busy);

// ===== test/lpt_host_model.sv
// lpt_host_model.sv: host side of the low pin count bus
// assumes the bench calls run, pull-ups on the nibble lines
`timescale 1ns/10ps
module lpt_host_model
	import lpt_pkg::*;
(
	// clock
	input wire logic clk,
	// device drive
	input wire logic [3:0] lad_out,
	input wire logic lad_oe,
	// bus as the device sees it
	output logic lframe_n,
	output logic [3:0] lad_in
);
	logic [3:0] lad_h;
	logic hoe;
	// resolved lines, pulled high when nobody drives
	assign lad_in = lad_oe ? (hoe ? 4'hx : lad_out) : (hoe ? lad_h : 4'hF);
	// idle host, frame high in reset
	initial begin
		lframe_n = 1'b1;
		hoe = 1'b0;
		lad_h = 4'hF;
	end
	// one nibble per clock with frame level
	task nib(input logic [3:0] v, input logic f);
		@(posedge clk);
		lad_h <= v;
		hoe <= 1'b1;
		lframe_n <= f;
	endtask
	// drive high one clock then float
	task tar();
		nib(4'hF, 1'b1);
		@(posedge clk);
		hoe <= 1'b0;
	endtask
	// whole cycle; nw counts waits, wc keeps last wait code
	task run(input logic [3:0] ct, input logic [15:0] a, input int n,
		input logic [31:0] wd, output logic [31:0] rd, output int nw,
		output logic [3:0] wc, output bit ok);
		bit hd;
		int k;
		hd = ct[3] ? !ct[1] : ct[1];
		rd = '0;
		nw = 0;
		wc = 4'h0;
		ok = 1'b0;
		nib(`LPT_START, 1'b0);
		nib(ct, 1'b1);
		for (k = 12; k >= 0; k -= 4) begin
			if (!ct[3] || k < 8) nib(a[k+:4], 1'b1);
		end
		for (int i = 0; i < n; i++) begin
			if (hd) begin
				nib(wd[8*i+:4], 1'b1);
				nib(wd[8*i+4+:4], 1'b1);
			end
			if (hd || i == 0) tar();
			ok = 1'b0;
			for (k = 0; k < 12 && !ok; k++) begin
				@(posedge clk);
				if (lad_oe && lad_out == `LPT_SYNC_READY) ok = 1'b1;
				else if (lad_oe) begin
					nw++;
					wc = lad_out;
				end
			end
			// no answer: abort the cycle
			if (!ok) begin
				repeat (4) nib(4'hF, 1'b0);
				tar();
				return;
			end
			if (!hd) begin
				@(posedge clk);
				rd[8*i+:4] = lad_out;
				@(posedge clk);
				rd[8*i+4+:4] = lad_out;
			end
			// device turnaround; a following host byte comes right after it
			if (i == n - 1) repeat (2) @(posedge clk);
			else if (hd) @(posedge clk);
		end
	endtask
endmodule

// ===== test/testbench.sv
// testbench.sv: self-checking bench for lpt_target
// assumes host model and checker bind compiled first
`timescale 1ns/10ps
module testbench
	import lpt_pkg::*;
;
	logic clk, nrst, lframe_n, lad_oe, ldrq_n, lpcpd_n, wake_request, wake_n, wake_oe;
	logic [3:0] lad_in, lad_out;
	logic [95:0] win_base, win_mask;
	logic [5:0] win_en, io_sel;
	logic [15:0] io_addr, wa;
	lpt_byte_type io_wdata, io_rdata, tx, rx, wdv, d;
	logic io_wr, io_rd, take, dma_en, dma_req, act, busy, pop, avail;
	logic [2:0] chan;
	int bad_count, samples_checked, cyc, rds, takes;
	lpt_target lpt_target_i (.clk, .nrst, .lframe_n, .lad_in, .lad_out, .lad_oe, .ldrq_n,
		.lpcpd_n, .wake_request, .wake_event_request_n(wake_n), .wake_oe, .win_base,
		.win_mask, .win_en, .io_addr, .io_wdata, .io_wr, .io_rd, .io_sel, .io_rdata,
		.dma_chan(chan), .dma_en, .dma_req, .dma_req_act(act), .dma_req_busy(busy),
		.dma_tx_data(tx), .dma_tx_take(take), .dma_rx_pop(pop), .dma_rx_data(rx),
		.dma_rx_avail(avail));
	lpt_host_model lpt_host_model_i (.clk, .lad_out, .lad_oe, .lframe_n, .lad_in);
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard and write capture
	always @(posedge clk) begin
		if (io_wr === 1'b1) begin
			wa <= io_addr;
			wdv <= io_wdata;
		end
		rds <= rds + int'(io_rd === 1'b1);
		takes <= takes + int'(take === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task stop_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// expected wait states per byte and bytes per size code
	function int waits(input logic [3:0] ct);
		return ct[3] ? (ct[1] ? `LPT_WAIT_DMA_WR : `LPT_WAIT_DMA_RD)
			: (ct[1] ? `LPT_WAIT_IO_WR : `LPT_WAIT_IO_RD);
	endfunction
	function int nb(input logic [1:0] s);
		return (s == `LPT_SIZE_4) ? 4 : int'(s) + 1;
	endfunction
	// one cycle with its checks
	task go(input logic [3:0] ct, input logic [15:0] a, input int n, input bit hit,
		input logic [31:0] wd, input logic [31:0] ed);
		logic [31:0] rd;
		int nw;
		logic [3:0] wc;
		bit ok;
		lpt_host_model_i.run(ct, a, n, wd, rd, nw, wc, ok);
		chk(32'(ok), 32'(hit));
		if (hit) begin
			chk(32'(nw), 32'(n * waits(ct)));
			chk(32'(wc), ct[3] ? 32'(`LPT_SYNC_SHORT) : 32'(`LPT_SYNC_LONG));
			chk(rd, ed);
		end
	endtask
	// main sequence
	initial begin
		logic [15:0] a;
		logic [31:0] w;
		logic [4:0] q;
		logic [1:0] sz [3] = '{`LPT_SIZE_1, `LPT_SIZE_2, `LPT_SIZE_4};
		logic [3:0] bad_ct [4] = '{4'h4, 4'h6, 4'hC, 4'hE};
		{nrst, dma_req, act, pop, wake_request} = 5'h00;
		{lpcpd_n, dma_en} = 2'h3;
		win_base = {80'h0, 16'h03F8};
		win_mask = {80'h0, 16'h0007};
		win_en = 6'h01;
		{io_rdata, tx} = 16'h0000;
		void'($urandom(32828));
		chan = 3'($urandom);
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		// random in-window writes and reads, window edges
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 16'h03FF : 16'h03F8 + 16'($urandom % 8);
			d = 8'($urandom);
			io_rdata <= d;
			go(4'h2, a, 1, 1'b1, 32'(d), 32'h0);
			chk({wa, wdv, io_sel}, {a, d, 6'h01});
			go(4'h0, a, 1, 1'b1, 32'h0, 32'(d));
		end
		chk(rds, 32'h8);
		go(4'h0, 16'h03F7, 1, 1'b0, 32'h0, 32'h0);
		go(4'h2, 16'h0400, 1, 1'b0, 32'h0, 32'h0);
		foreach (bad_ct[i]) go(bad_ct[i], 16'h03F8, 1, 1'b0, 32'h0, 32'h0);
		// dma both ways at each size, then a foreign channel
		foreach (sz[i]) begin
			w = $urandom;
			go(4'h8, {8'h0, 1'b0, chan, 2'b0, sz[i]}, nb(sz[i]), 1'b1, w, 32'h0);
			for (int j = 0; j < nb(sz[i]); j++) begin
				repeat (3) @(posedge clk);
				chk(32'(rx), 32'(w[8*j+:8]));
				pop <= 1'b1;
				@(posedge clk);
				pop <= 1'b0;
			end
			repeat (3) @(posedge clk);
			chk(32'(avail), 32'h0);
			d = 8'($urandom);
			tx <= d;
			go(4'hA, {8'h0, 1'b0, chan, 2'b0, sz[i]}, nb(sz[i]), 1'b1, 32'h0,
				{4{d}} >> (32 - 8 * nb(sz[i])));
		end
		chk(takes, 32'h7);
		go(4'h8, {8'h0, 1'b0, chan + 3'h1, 4'h0}, 1, 1'b0, 32'h0, 32'h0);
		// overfill the receive store: error sync, never ready
		repeat (2) go(4'h8, {8'h0, 1'b0, chan, 4'h3}, 4, 1'b1, w, 32'h0);
		go(4'h8, {8'h0, 1'b0, chan, 4'h0}, 1, 1'b0, 32'h0, 32'h0);
		chk(32'(avail), 32'h1);
		// request frames with both active values
		for (int i = 0; i < 2; i++) begin
			dma_req <= 1'b1;
			act <= i[0];
			@(posedge clk);
			dma_req <= 1'b0;
			@(posedge clk);
			for (int b = 0; b < 5; b++) begin
				@(posedge clk);
				q = {q[3:0], ldrq_n};
			end
			chk(32'(q), 32'({1'b0, chan, i[0]}));
			repeat (2) @(posedge clk);
			chk({busy, ldrq_n}, 2'h1);
		end
		// wake pull, then power-down notice and recovery
		wake_request <= 1'b1;
		repeat (5) @(posedge clk);
		chk({wake_oe, wake_n}, 2'h2);
		wake_request <= 1'b0;
		lpcpd_n <= 1'b0;
		repeat (4) @(posedge clk);
		go(4'h0, 16'h03F8, 1, 1'b0, 32'h0, 32'h0);
		lpcpd_n <= 1'b1;
		// disabled then relocated window
		win_en <= 6'h00;
		repeat (4) @(posedge clk);
		go(4'h0, 16'h03F8, 1, 1'b0, 32'h0, 32'h0);
		win_base <= {80'h0, 16'h02F8};
		win_en <= 6'h01;
		go(4'h0, 16'h02FA, 1, 1'b1, 32'h0, 32'(io_rdata));
		stop_test();
	end
endmodule
